// ===== sar_adc_conversion_sequencer.sv
/*
 * Conversion sequencer of a serially controlled SAR converter: power
 * management, track/hold control and serial result shift-out.
 * Assumes chip select and serial clock arrive asynchronously from a host
 * and that the sample code is a stable input from the analog core.
 */
`timescale 1ns/1ps
module sar_adc_conversion_sequencer #(
	parameter int RES = 12 // 12, 10 or 8
) (
	// Clock, reset, enable
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic CE_I,
	// Serial link from host
	input wire logic CS_N_I,
	input wire logic SCLK_I,
	// Sample from analog core, straight binary
	input wire logic [RES-1:0] SAMPLE_I,
	// Serial data pin
	output logic SDATA_O,
	output logic SDATA_OE_O,
	// Analog control
	output logic POWER_UP_O,
	output logic TRACK_O,
	output logic BUSY_O
);
	// Frame length follows resolution
	localparam logic [4:0] FRAME = sar_seq_pkg::frame_len(RES);
	localparam int SW = RES + sar_seq_pkg::LEAD_ZEROS;

	logic cs_level, cs_rise, cs_fall;
	logic sck_level, sck_fall;

	// Select pin synchroniser
	sar_pin_sync u_cs (
		.clk_i(CLK_I),
		.rst_i(RESET_I),
		.ce_i(CE_I),
		.pin_i(CS_N_I),
		.level_o(cs_level),
		.rise_o(cs_rise),
		.fall_o(cs_fall)
	);

	// Serial clock synchroniser; rising edges unused
	sar_pin_sync u_sck (
		.clk_i(CLK_I),
		.rst_i(RESET_I),
		.ce_i(CE_I),
		.pin_i(SCLK_I),
		.level_o(sck_level),
		.rise_o(),
		.fall_o(sck_fall)
	);

	sar_seq_pkg::seq_state_e st_q, st_d; // Sequencer state
	logic [4:0] cnt_q, cnt_d; // Falling edges in this frame
	logic [SW-1:0] sh_q, sh_d; // Output shift register
	logic oe_q, oe_d; // Data pin drive
	logic pu_q, pu_d; // Power up request
	logic trk_q, trk_d; // Track (1) or hold (0)
	logic [SW-1:0] sh_shift; // Shift register moved one place, for checks
	logic active; // Frame running: track or convert

	// Helpers read only by the checks below
	assign sh_shift = {sh_q[SW-2:0], 1'b0};
	assign active = (st_q == sar_seq_pkg::ST_TRACK) ||
		(st_q == sar_seq_pkg::ST_CONVERT);

	// Next-state logic: all timing derives from serial edges
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		oe_d = oe_q;
		pu_d = pu_q;
		trk_d = trk_q;
		if (!CE_I) begin
			// Frozen
		end else if (cs_level) begin
			// Select high: counter cleared, early rise aborts
			cnt_d = sar_seq_pkg::COUNT_RST;
			if (cs_rise && st_q != sar_seq_pkg::ST_POWER_DOWN) begin
				st_d = sar_seq_pkg::ST_POWER_DOWN;
				oe_d = 1'b0;
				pu_d = 1'b0;
				trk_d = 1'b0;
			end
		end else if (cs_fall) begin
			// Start: power up, track, drive first zero
			st_d = sar_seq_pkg::ST_TRACK;
			pu_d = 1'b1;
			trk_d = 1'b1;
			oe_d = 1'b1;
			sh_d = {{sar_seq_pkg::LEAD_ZEROS{1'b0}}, SAMPLE_I};
			cnt_d = sar_seq_pkg::COUNT_RST;
		end else if (sck_fall && st_q != sar_seq_pkg::ST_POWER_DOWN &&
				st_q != sar_seq_pkg::ST_DONE) begin
			cnt_d = cnt_q + 5'h01;
			sh_d = {sh_q[SW-2:0], 1'b0};
			if (cnt_d == sar_seq_pkg::HOLD_EDGE) begin
				trk_d = 1'b0;
				st_d = sar_seq_pkg::ST_CONVERT;
			end
			if (cnt_d == FRAME) begin
				// Last edge: tri-state and sleep
				st_d = sar_seq_pkg::ST_DONE;
				oe_d = 1'b0;
				pu_d = 1'b0;
				trk_d = 1'b0;
			end
		end
	end

	// State registers
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			st_q <= sar_seq_pkg::ST_POWER_DOWN;
			cnt_q <= sar_seq_pkg::COUNT_RST;
			sh_q <= '0;
			oe_q <= 1'b0;
			pu_q <= 1'b0;
			trk_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			oe_q <= oe_d;
			pu_q <= pu_d;
			trk_q <= trk_d;
		end
	end

	// Outputs straight from flops; data is the shift MSB
	assign SDATA_O = sh_q[SW-1];
	assign SDATA_OE_O = oe_q;
	assign POWER_UP_O = pu_q;
	assign TRACK_O = trk_q;
	assign BUSY_O = pu_q;

	// Checks
	sequence s_start;
		CE_I && !cs_level && cs_fall;
	endsequence

	a_start_powers_up: assert property (@(posedge CLK_I) disable iff (RESET_I)
		s_start |=> pu_q && trk_q && oe_q)
		else $error("start did not power up");
	a_first_bit_zero: assert property (@(posedge CLK_I) disable iff (RESET_I)
		s_start |=> !SDATA_O)
		else $error("first lead bit not zero");
	a_hold_third: assert property (@(posedge CLK_I) disable iff (RESET_I)
		$fell(trk_q) && $past(cs_level) == 1'b0 && oe_q
		|-> cnt_q == sar_seq_pkg::HOLD_EDGE)
		else $error("hold not on third edge");
	a_frame_end: assert property (@(posedge CLK_I) disable iff (RESET_I)
		$fell(oe_q) && !$past(cs_level) |-> cnt_q == FRAME)
		else $error("frame ended on wrong edge");
	a_abort_rise: assert property (@(posedge CLK_I) disable iff (RESET_I)
		CE_I && cs_rise |=> !oe_q && !pu_q && !trk_q)
		else $error("select rise did not abort");
	a_count_clear: assert property (@(posedge CLK_I) disable iff (RESET_I)
		CE_I && cs_level |=> cnt_q == sar_seq_pkg::COUNT_RST)
		else $error("count not cleared");
	a_sleep_done: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == sar_seq_pkg::ST_DONE |-> !pu_q && !oe_q)
		else $error("not powered down after conversion");
	a_no_edge_idle: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == sar_seq_pkg::ST_DONE && !cs_fall |=> cnt_q == $past(cnt_q)
		|| cnt_q == sar_seq_pkg::COUNT_RST)
		else $error("count moved while asleep");

	// A serial fall inside a running frame, no select edge in the way
	sequence s_shift;
		CE_I && !cs_level && !cs_fall && sck_fall && active;
	endsequence

	// Select seen high with the block still awake
	sequence s_cut;
		CE_I && cs_rise && active;
	endsequence

	// Each fall in a frame moves the next bit to the pin
	a_shift_next_bit: assert property (@(posedge CLK_I) disable iff (RESET_I)
		s_shift |=> sh_q == $past(sh_shift))
		else $error("serial fall did not shift");
	// The frame opens with the zeros and then the sample code
	a_load_sample: assert property (@(posedge CLK_I) disable iff (RESET_I)
		s_start |=> sh_q[RES-1:0] == $past(SAMPLE_I) &&
		sh_q[SW-1:RES] == '0)
		else $error("sample not loaded behind zeros");
	// The count never passes the frame length of this resolution
	a_count_bound: assert property (@(posedge CLK_I) disable iff (RESET_I)
		cnt_q <= FRAME)
		else $error("count beyond frame length");
	// A cut frame leaves the sequencer asleep
	a_cut_sleeps: assert property (@(posedge CLK_I) disable iff (RESET_I)
		s_cut |=> st_q == sar_seq_pkg::ST_POWER_DOWN)
		else $error("cut frame not asleep");
	// The data pin is never driven while the core is powered down
	a_no_drive_off: assert property (@(posedge CLK_I) disable iff (RESET_I)
		!pu_q |-> !oe_q)
		else $error("pin driven while powered down");
	// Track only ever stands while the core is powered
	a_track_powered: assert property (@(posedge CLK_I) disable iff (RESET_I)
		trk_q |-> pu_q)
		else $error("track without power");
endmodule : sar_adc_conversion_sequencer

// ===== sar_seq_pkg.sv
/*
 * Shared constants for the SAR conversion sequencer.
 * Assumes a 40 MHz system clock; no software-visible registers exist.
 */
package sar_seq_pkg;
	// System clock
	localparam int CLK_PERIOD_NS = 25;
	// Leading zeros in every frame
	localparam int LEAD_ZEROS = 4;
	// Falling edge that ends the track phase
	localparam logic [4:0] HOLD_EDGE = 5'h03;
	// Frame lengths per resolution
	localparam logic [4:0] FRAME_12 = 5'h10;
	localparam logic [4:0] FRAME_10 = 5'h0E;
	localparam logic [4:0] FRAME_8 = 5'h0C;
	// Reset value of the edge counter
	localparam logic [4:0] COUNT_RST = 5'h00;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_POWER_DOWN = 2'b00,
		ST_TRACK = 2'b01,
		ST_CONVERT = 2'b10,
		ST_DONE = 2'b11
	} seq_state_e;

	// Frame length from resolution
	function automatic logic [4:0] frame_len(input int res);
		frame_len = (res == 12) ? FRAME_12 :
			(res == 10) ? FRAME_10 : FRAME_8;
	endfunction : frame_len
endpackage : sar_seq_pkg

// ===== sar_pin_sync.sv
/*
 * Two-flop synchroniser with edge detection for one asynchronous pin.
 * Assumes the pin changes slower than half the system clock rate.
 */
`timescale 1ns/1ps
module sar_pin_sync (
	// Clock and control
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Pin and results
	input wire logic pin_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	logic [2:0] sh_q; // Two sync flops and a history flop
	logic [2:0] sh_d;

	// Next value of the shift chain
	always_comb begin
		sh_d = ce_i ? {sh_q[1:0], pin_i} : sh_q;
	end

	// Registering only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Both pins idle high; a zero here would fake an edge
			sh_q <= 3'h7;
		end else begin
			sh_q <= sh_d;
		end
	end

	// Only flops 1 and 2 are looked at; flop 0 may be metastable
	assign level_o = sh_q[1];
	assign rise_o = ce_i & sh_q[1] & ~sh_q[2];
	assign fall_o = ce_i & ~sh_q[1] & sh_q[2];
endmodule : sar_pin_sync

// ===== host_model.sv
/* Host serial master model for the conversion sequencer.
   Assumes the device shows each bit within 100 ns of a clock fall. */
`timescale 1ns/1ps
module host_model (
	// Data pin from device
	input wire logic sdata_i,
	// Link outputs
	output logic cs_n_o,
	output logic sclk_o
);
	// Idle: deselected, clock parked high
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b1;
	end
	// One frame of nf falls; select rises at fall ab
	task automatic frame(input int nf, input int ab, input bit hold,
		output logic [15:0] w);
		w = '0;
		cs_n_o = 1'b0;
		#250 w[15] = sdata_i;
		for (int i = 1; i <= nf; i++) begin
			sclk_o = 1'b0;
			if (i == ab) begin
				cs_n_o = 1'b1;
				break;
			end
			#100 sclk_o = 1'b1;
			// Sample late, just before the next fall
			#95 if (i < nf) w[15-i] = sdata_i;
			#5;
		end
		#100 sclk_o = 1'b1;
		if (!hold) cs_n_o = 1'b1;
		#300; // Quiet interval
	endtask : frame
	// Free clocks outside a frame, select at level cs
	task automatic idle_clk(input int n, input bit cs);
		cs_n_o = cs;
		repeat (n) begin
			#100 sclk_o = 1'b0;
			#100 sclk_o = 1'b1;
		end
	endtask : idle_clk
endmodule : host_model

// ===== tb.sv
/* Self-checking bench for the conversion sequencer, 12-bit variant.
   Assumes the host model paces the serial link. */
`timescale 1ns/1ps
module tb;
	logic CLK_I = 1'b0;
	logic RESET_I = 1'b1;
	logic [11:0] sample = 12'h000;
	logic cs_n, sclk, sdata, oe, pu, trk, busy;
	logic [15:0] w, trk_seen, on_seen;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int nf = 0;
	always #12.5 CLK_I = ~CLK_I;
	sar_adc_conversion_sequencer #(.RES(12)) DUT (.CLK_I(CLK_I),
		.RESET_I(RESET_I), .CE_I(1'b1), .CS_N_I(cs_n), .SCLK_I(sclk),
		.SAMPLE_I(sample), .SDATA_O(sdata), .SDATA_OE_O(oe),
		.POWER_UP_O(pu), .TRACK_O(trk), .BUSY_O(busy));
	host_model host (.sdata_i(sdata), .cs_n_o(cs_n), .sclk_o(sclk));
	// State just before each fall, index = falls so far
	always @(negedge sclk) begin
		if (!cs_n && nf < 16) begin
			trk_seen[nf] = trk;
			on_seen[nf] = oe & pu & busy;
			nf++;
		end
	end
	// Hang guard, far above the roughly one thousand cycles needed
	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// Whole frame: data, track window, power window
	task automatic t_full(input logic [11:0] v);
		@(negedge CLK_I) sample = v;
		nf = 0;
		host.frame(16, 0, 0, w);
		check("word", w, {4'h0, v});
		check("track", trk_seen, 16'h0007);
		check("on", on_seen, 16'hFFFF);
		check("idle", {oe, pu, trk}, 16'h0000);
		$display("full %h done", v);
	endtask : t_full
	// Early select rise, then clocks while deselected
	task automatic t_abort();
		@(negedge CLK_I) sample = 12'h7FF;
		host.frame(16, 5, 0, w);
		check("head", w[15:11], 16'h0000);
		check("abort", {oe, pu, trk}, 16'h0000);
		host.idle_clk(4, 1'b1);
		check("ignored", {oe, pu, busy}, 16'h0000);
		$display("abort done");
	endtask : t_abort
	// Select held low past the frame end
	task automatic t_hold();
		host.frame(16, 0, 1, w);
		host.idle_clk(3, 1'b0);
		check("asleep", {oe, pu, busy}, 16'h0000);
		host.idle_clk(2, 1'b1); // Quiet time before next frame
		$display("hold done");
	endtask : t_hold
	initial begin
		repeat (10) @(posedge CLK_I);
		@(negedge CLK_I) RESET_I = 1'b0;
		host.frame(16, 0, 0, w); // Dummy first frame
		t_full(12'hA5C);
		t_abort();
		t_full(12'hFFF); // Count cleared after abort
		t_hold();
		t_full(12'h001);
		stop_test();
	end
endmodule : tb
